// ==== servo_io_pkg.sv ====
`default_nettype none
package servo_io_pkg;
// Behaviour
// - format selects quadrature, two trains, pulse-direction
// - invert setting swaps forward and reverse
// - each inhibit input blocks its own direction
// - inhibit disable setting ignores both inhibits
// - stop selection applies while inhibits enabled
// - analog input is speed or torque command
// - power stage on while servo-on asserted and held through the stop wait
// - deviation clear follows selected trigger condition
// - alarm clears after 120 ms held input
// - alarm clear also clears deviation counter
// - modes 3, 4, 5 switch between two modes
// - pulse inhibit off blocks command pulses
// - speed mode picks eight presets; torque ignores
// - divided encoder output, never above 4 Mpps
// - phase direction setting sets B against A
// - brake interlock timed by two delay settings
// - ready after main power with no error
// - fault output off at reset and error
// - positioning done when deviation within range
// - other modes flag speed above threshold
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] REG_CFG = 5'h00;
  localparam logic [4:0] REG_NUM = 5'h01;
  localparam logic [4:0] REG_DEN = 5'h02;
  localparam logic [4:0] REG_BRK_STOP = 5'h03;
  localparam logic [4:0] REG_BRK_RUN = 5'h04;
  localparam logic [4:0] REG_INP_RANGE = 5'h05;
  localparam logic [4:0] REG_ROT_SPD = 5'h06;
  localparam logic [4:0] REG_SPD_SCALE = 5'h07;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_DEV = 5'h09;
  localparam logic [4:0] REG_PRESET0 = 5'h10;
  localparam int CFG_INV = 0, CFG_FMT = 1, CFG_INH_DIS = 3, CFG_STOP = 4;
  localparam int CFG_MODE = 6, CFG_IPG_DIS = 9, CFG_CLR_EDGE = 10;
  localparam int CFG_PHASE = 11, CFG_INP_COND = 12, CFG_PRESET = 13;
  localparam int CFG_INIT = 14;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] RATIO_RST = 16'h0001;
  localparam logic [15:0] SCALE_RST = 16'h0100;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [1:0] FMT_CWCCW = 2'h1, FMT_PDIR = 2'h3;
  localparam int P_A = 0, P_B = 1, P_ENCA = 2, P_ENCB = 3, P_FINH = 4;
  localparam int P_RINH = 5, P_SVON = 6, P_DCLR = 7, P_ACLR = 8;
  localparam int P_MSW = 9, P_IPG = 10, P_GSEL = 11, P_MPWR = 12, NPIN = 13;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int DEV_CLR_MIN_MS = 1;
  localparam int ALM_CLR_MS = 120;
  localparam int ALM_CLR_CYC = ALM_CLR_MS * MS_CYC;
  localparam int ENC_MAX_PPS = 4_000_000;
  localparam int ENC_GAP_CYC = (CLK_HZ + ENC_MAX_PPS - 1) / ENC_MAX_PPS;
  typedef enum logic [1:0] {MODE_POS = 2'b00, MODE_SPD = 2'b01, MODE_TRQ = 2'b10} mode_t;
  typedef enum logic [1:0] {BRK_IDLE = 2'b00, BRK_RUN = 2'b01, BRK_STOP_WAIT = 2'b10,
                            BRK_RUN_WAIT = 2'b11} brk_t;
endpackage
`default_nettype wire

// ==== servo_command_io_logic.sv ====
`timescale 1ns/100ps
`default_nettype none
module servo_command_io_logic import servo_io_pkg::*; #(
  parameter int ALM_CLR_CYCLES = ALM_CLR_CYC,
  parameter int MS_CYCLES      = MS_CYC,
  parameter int DEV_W          = 32,
  parameter int SPD_W          = 16
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [DATA_W-1:0]       reg_rdata,
  input  wire logic                    reverse_pulse_in,
  input  wire logic                    forward_pulse_in,
  input  wire logic                    enc_a_in,
  input  wire logic                    enc_b_in,
  input  wire logic                    forward_inhibit,
  input  wire logic                    reverse_inhibit,
  input  wire logic                    servo_on_in,
  input  wire logic                    deviation_clear,
  input  wire logic                    alarm_clear_in,
  input  wire logic                    mode_switch_in,
  input  wire logic                    pulse_inhibit,
  input  wire logic                    gain_select_in,
  input  wire logic                    main_power_in,
  input  wire logic                    fault_detect,
  input  wire logic [SPD_W-1:0]        motor_speed,
  input  wire logic signed [SPD_W-1:0] torque_cmd_analog,
  output logic                         power_enable,
  output logic                         brake_interlock,
  output logic                         ready_out,
  output logic                         fault_out_n,
  output logic                         positioning_done,
  output logic                         enc_a_out,
  output logic                         enc_b_out,
  output logic                         fwd_block,
  output logic                         rev_block,
  output logic      [1:0]              stop_mode,
  output logic      [1:0]              active_mode,
  output logic signed [SPD_W-1:0]      speed_ref,
  output logic signed [SPD_W-1:0]      torque_ref
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // pin inputs: three stages, a level counts once stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] pin_r;
  logic [NPIN-1:0] pin_d_r;

  assign pin_raw = {main_power_in, gain_select_in, pulse_inhibit, mode_switch_in,
                    alarm_clear_in, deviation_clear, servo_on_in, reverse_inhibit,
                    forward_inhibit, enc_b_in, enc_a_in, forward_pulse_in, reverse_pulse_in};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_d_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_d_r <= pin_r;
    end
  end

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pin_r[i] <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        pin_r[i] <= s3_r[i];
      end
    end
  end

  // settings
  logic [15:0]      cfg_r;
  logic [15:0]      num_r;
  logic [15:0]      den_r;
  logic [15:0]      brk_stop_r;
  logic [15:0]      brk_run_r;
  logic [15:0]      inp_range_r;
  logic [15:0]      rot_spd_r;
  logic [15:0]      scale_r;
  logic [SPD_W-1:0] preset_r [0:7];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_r <= CFG_RST;
      num_r <= RATIO_RST;
      den_r <= RATIO_RST;
      brk_stop_r <= ZERO16;
      brk_run_r <= ZERO16;
      inp_range_r <= ZERO16;
      rot_spd_r <= ZERO16;
      scale_r <= SCALE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CFG:       cfg_r <= reg_wdata[15:0];
        REG_NUM:       num_r <= reg_wdata[15:0];
        REG_DEN:       den_r <= reg_wdata[15:0];
        REG_BRK_STOP:  brk_stop_r <= reg_wdata[15:0];
        REG_BRK_RUN:   brk_run_r <= reg_wdata[15:0];
        REG_INP_RANGE: inp_range_r <= reg_wdata[15:0];
        REG_ROT_SPD:   rot_spd_r <= reg_wdata[15:0];
        REG_SPD_SCALE: scale_r <= reg_wdata[15:0];
        default:       ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int k = 0; k < 8; k++) begin
        preset_r[k] <= '0;
      end
    end else if (reg_wr && reg_addr[ADDR_W-1:3] == REG_PRESET0[ADDR_W-1:3]) begin
      preset_r[reg_addr[2:0]] <= reg_wdata[SPD_W-1:0];
    end
  end

  logic       inv;
  logic [1:0] fmt;
  logic       inh_dis;
  logic [2:0] mode_sel;
  logic       ipg_dis;
  logic       clr_edge;
  logic       phase_dir;
  logic       inp_cond;
  logic       preset_en;
  logic       init_done;

  assign inv       = cfg_r[CFG_INV];
  assign fmt       = cfg_r[CFG_FMT +: 2];
  assign inh_dis   = cfg_r[CFG_INH_DIS];
  assign mode_sel  = cfg_r[CFG_MODE +: 3];
  assign ipg_dis   = cfg_r[CFG_IPG_DIS];
  assign clr_edge  = cfg_r[CFG_CLR_EDGE];
  assign phase_dir = cfg_r[CFG_PHASE];
  assign inp_cond  = cfg_r[CFG_INP_COND];
  assign preset_en = cfg_r[CFG_PRESET];
  assign init_done = cfg_r[CFG_INIT];

  // control mode
  mode_t mode_r;
  mode_t mode_nxt;

  always_comb begin
    case (mode_sel)
      3'd1:    mode_nxt = MODE_SPD;
      3'd2:    mode_nxt = MODE_TRQ;
      3'd3:    mode_nxt = pin_r[P_MSW] ? MODE_SPD : MODE_POS;
      3'd4:    mode_nxt = pin_r[P_MSW] ? MODE_TRQ : MODE_POS;
      3'd5:    mode_nxt = pin_r[P_MSW] ? MODE_TRQ : MODE_SPD;
      default: mode_nxt = MODE_POS;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_r <= MODE_POS;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // {step, forward} of a x4 quadrature pair; a double jump is dropped
  function automatic logic [1:0] quad_dec(input logic a, ad, b, bd);
    logic moved;
    moved = (a ^ ad) ^ (b ^ bd);
    return {moved, a ^ bd};
  endfunction

  logic [1:0] quad_cmd;
  logic [1:0] quad_fb;
  logic       cmd_step;
  logic       cmd_up;
  logic       ipg_block;
  logic       fwd_inh;
  logic       rev_inh;
  logic       cmd_ok;
  logic       run_now;

  assign quad_cmd = quad_dec(pin_r[P_A], pin_d_r[P_A], pin_r[P_B], pin_d_r[P_B]);
  assign quad_fb  = quad_dec(pin_r[P_ENCA], pin_d_r[P_ENCA], pin_r[P_ENCB], pin_d_r[P_ENCB]);

  always_comb begin
    case (fmt)
      FMT_CWCCW: begin
        cmd_step = (pin_r[P_A] & ~pin_d_r[P_A]) ^ (pin_r[P_B] & ~pin_d_r[P_B]);
        cmd_up   = pin_r[P_B] & ~pin_d_r[P_B];
      end
      FMT_PDIR: begin
        cmd_step = pin_r[P_A] & ~pin_d_r[P_A];
        cmd_up   = pin_r[P_B];
      end
      default: begin
        cmd_step = quad_cmd[1];
        cmd_up   = quad_cmd[0];
      end
    endcase
    cmd_up = cmd_up ^ inv;
  end

  assign fwd_inh   = ~inh_dis & pin_r[P_FINH];
  assign rev_inh   = ~inh_dis & pin_r[P_RINH];
  assign ipg_block = (mode_r == MODE_POS) & ~ipg_dis & ~pin_r[P_IPG];
  assign cmd_ok    = cmd_step & (mode_r == MODE_POS) & run_now & ~ipg_block
                     & ~(cmd_up ? fwd_inh : rev_inh);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fwd_block <= 1'b0;
      rev_block <= 1'b0;
      stop_mode <= 2'h0;
    end else begin
      fwd_block <= fwd_inh;
      rev_block <= rev_inh;
      stop_mode <= inh_dis ? 2'h0 : cfg_r[CFG_STOP +: 2];
    end
  end

  // alarm: set wins over the held clear
  logic        alarm_r;
  logic [31:0] clr_cnt_r;
  logic        alm_clr_fire;

  assign alm_clr_fire = pin_r[P_ACLR] && clr_cnt_r == 32'(ALM_CLR_CYCLES - 1);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clr_cnt_r <= '0;
    end else if (!pin_r[P_ACLR]) begin
      clr_cnt_r <= '0;
    end else if (clr_cnt_r != 32'(ALM_CLR_CYCLES)) begin
      clr_cnt_r <= clr_cnt_r + 32'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alarm_r <= 1'b0;
    end else if (fault_detect) begin
      alarm_r <= 1'b1;
    end else if (alm_clr_fire) begin
      alarm_r <= 1'b0;
    end
  end

  // deviation counter
  logic signed [DEV_W-1:0] dev_r;
  logic signed [DEV_W:0]   dev_sum;
  logic signed [1:0]       cmd_d;
  logic signed [1:0]       fb_d;
  logic                    dev_clr_fire;
  logic [DEV_W-1:0]        dev_abs;

  assign cmd_d = cmd_ok ? (cmd_up ? 2'sd1 : -2'sd1) : 2'sd0;
  assign fb_d  = quad_fb[1] ? (quad_fb[0] ? 2'sd1 : -2'sd1) : 2'sd0;
  assign dev_sum = {dev_r[DEV_W-1], dev_r} + (DEV_W+1)'(cmd_d) - (DEV_W+1)'(fb_d);
  assign dev_clr_fire = (mode_r == MODE_POS) &&
                        (clr_edge ? (pin_r[P_DCLR] & ~pin_d_r[P_DCLR]) : pin_r[P_DCLR]);
  assign dev_abs = dev_r[DEV_W-1] ? DEV_W'(-dev_r) : DEV_W'(dev_r);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dev_r <= '0;
    end else if (dev_clr_fire || alm_clr_fire) begin
      dev_r <= '0;
    end else if (dev_sum[DEV_W] != dev_sum[DEV_W-1]) begin
      // saturate so a runaway never flips the sign seen by the loop
      dev_r <= dev_sum[DEV_W] ? {1'b1, {(DEV_W-1){1'b0}}} : {1'b0, {(DEV_W-1){1'b1}}};
    end else begin
      dev_r <= dev_sum[DEV_W-1:0];
    end
  end

  // brake sequence on a millisecond tick
  brk_t        brk_r;
  brk_t        brk_nxt;
  logic [31:0] ms_cnt_r;
  logic        ms_tick;
  logic [15:0] brk_cnt_r;
  logic        run_ok;
  logic        moving;

  assign ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);
  assign run_ok  = pin_r[P_SVON] & pin_r[P_MPWR] & ~alarm_r;
  assign moving  = motor_speed > SPD_W'(rot_spd_r);
  assign run_now = brk_r == BRK_RUN;

  always_comb begin
    case (brk_r)
      BRK_IDLE:      brk_nxt = run_ok ? BRK_RUN : BRK_IDLE;
      BRK_RUN: begin
        if (run_ok) begin
          brk_nxt = BRK_RUN;
        end else if (moving || alarm_r || !pin_r[P_MPWR]) begin
          brk_nxt = BRK_RUN_WAIT;
        end else begin
          brk_nxt = BRK_STOP_WAIT;
        end
      end
      BRK_STOP_WAIT: brk_nxt = (brk_cnt_r >= brk_stop_r || alarm_r) ? BRK_IDLE : BRK_STOP_WAIT;
      BRK_RUN_WAIT:  brk_nxt = (brk_cnt_r >= brk_run_r || !moving) ? BRK_IDLE : BRK_RUN_WAIT;
      default:       brk_nxt = BRK_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_tick ? 32'd0 : ms_cnt_r + 32'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      brk_r <= BRK_IDLE;
      brk_cnt_r <= '0;
    end else begin
      brk_r <= brk_nxt;
      if (brk_nxt != brk_r) begin
        brk_cnt_r <= '0;
      end else if (ms_tick && brk_cnt_r != 16'hffff) begin
        brk_cnt_r <= brk_cnt_r + 16'd1;
      end
    end
  end

  // status outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_enable <= 1'b0;
      brake_interlock <= 1'b0;
      ready_out <= 1'b0;
      fault_out_n <= 1'b0;
      active_mode <= 2'b00;
    end else begin
      // stop wait keeps current on so the load is held while the brake bites
      power_enable <= (brk_nxt == BRK_RUN || brk_nxt == BRK_STOP_WAIT)
                      & pin_r[P_MPWR] & ~alarm_r;
      brake_interlock <= brk_nxt == BRK_RUN || brk_nxt == BRK_RUN_WAIT;
      ready_out <= init_done & pin_r[P_MPWR] & ~alarm_r & ~fault_detect;
      fault_out_n <= init_done & ~alarm_r;
      active_mode <= mode_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      positioning_done <= 1'b0;
    end else if (mode_r == MODE_POS) begin
      positioning_done <= dev_abs < DEV_W'(inp_range_r) && (!inp_cond || !cmd_ok);
    end else begin
      positioning_done <= moving;
    end
  end

  // command references
  logic [2:0]           sel;
  logic signed [32:0]   scaled;

  assign sel    = {pin_r[P_GSEL], pin_r[P_DCLR], pin_r[P_IPG]};
  assign scaled = torque_cmd_analog * $signed({1'b0, scale_r});

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      speed_ref <= '0;
      torque_ref <= '0;
    end else begin
      speed_ref <= '0;
      torque_ref <= '0;
      if (run_now && mode_r == MODE_SPD) begin
        speed_ref <= preset_en ? preset_r[sel] : scaled[SPD_W+7:8];
      end
      if (run_now && mode_r == MODE_TRQ) begin
        torque_ref <= torque_cmd_analog;
      end
    end
  end

  // divided encoder output; excess steps queue behind the rate limit
  logic [16:0]        acc_r;
  logic [16:0]        acc_sum;
  logic signed [15:0] pend_r;
  logic [4:0]         gap_r;
  logic [1:0]         q_r;
  logic               enc_due;
  logic               enc_emit;
  logic               emit_up;

  assign acc_sum  = acc_r + {1'b0, num_r};
  assign enc_due  = quad_fb[1] && acc_sum >= {1'b0, den_r};
  assign enc_emit = pend_r != 16'sd0 && gap_r == 5'd0;
  assign emit_up  = ~pend_r[15];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc_r <= '0;
      pend_r <= '0;
      gap_r <= '0;
      q_r <= 2'b00;
    end else begin
      if (quad_fb[1]) begin
        acc_r <= enc_due ? acc_sum - {1'b0, den_r} : acc_sum;
      end
      pend_r <= pend_r + (enc_due ? (quad_fb[0] ? 16'sd1 : -16'sd1) : 16'sd0)
                - (enc_emit ? (emit_up ? 16'sd1 : -16'sd1) : 16'sd0);
      if (enc_emit) begin
        gap_r <= 5'(ENC_GAP_CYC - 1);
        q_r <= emit_up ? q_r + 2'd1 : q_r - 2'd1;
      end else if (gap_r != 5'd0) begin
        gap_r <= gap_r - 5'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enc_a_out <= 1'b0;
      enc_b_out <= 1'b0;
    end else begin
      enc_a_out <= q_r[1];
      enc_b_out <= q_r[1] ^ q_r[0] ^ phase_dir;
    end
  end

  // register reads: data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset || !reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr[ADDR_W-1:3] == REG_PRESET0[ADDR_W-1:3]) begin
      reg_rdata <= DATA_W'(preset_r[reg_addr[2:0]]);
    end else begin
      case (reg_addr)
        REG_CFG:       reg_rdata <= {16'h0000, cfg_r};
        REG_NUM:       reg_rdata <= {16'h0000, num_r};
        REG_DEN:       reg_rdata <= {16'h0000, den_r};
        REG_BRK_STOP:  reg_rdata <= {16'h0000, brk_stop_r};
        REG_BRK_RUN:   reg_rdata <= {16'h0000, brk_run_r};
        REG_INP_RANGE: reg_rdata <= {16'h0000, inp_range_r};
        REG_ROT_SPD:   reg_rdata <= {16'h0000, rot_spd_r};
        REG_SPD_SCALE: reg_rdata <= {16'h0000, scale_r};
        REG_STATUS:    reg_rdata <= {23'h000000, brk_r, positioning_done, brake_interlock,
                                     power_enable, ready_out, alarm_r, mode_r};
        REG_DEV:       reg_rdata <= DATA_W'(dev_r);
        default:       reg_rdata <= '0;
      endcase
    end
  end

  chk_fwd_inhibit_blocks: assert property (
    fwd_inh |-> !(cmd_ok && cmd_up)) else $error("forward pulse passed inhibit");
  chk_inhibit_disabled: assert property (
    inh_dis |=> !fwd_block && !rev_block && stop_mode == 2'h0) else $error("inhibit not ignored");
  chk_power_needs_run: assert property (
    (!pin_r[P_MPWR] || alarm_r) |=> !power_enable) else $error("power stage on without run");
  chk_alarm_clear_hold: assert property (
    $fell(alarm_r) |-> $past(clr_cnt_r) == 32'(ALM_CLR_CYCLES - 1)) else $error("alarm cleared early");
  chk_alarm_clears_dev: assert property (
    $fell(alarm_r) |-> dev_r == '0) else $error("deviation kept on alarm clear");
  chk_mode_switch_trq: assert property (
    (mode_sel == 3'd4 && pin_r[P_MSW]) |=> mode_r == MODE_TRQ ##1 active_mode == MODE_TRQ)
    else $error("mode switch ignored");
  chk_pulse_inhibit: assert property (
    ipg_block |-> dev_sum >= {dev_r[DEV_W-1], dev_r} - (DEV_W+1)'(fb_d) && !cmd_ok)
    else $error("pulse passed while inhibited");
  chk_enc_spacing: assert property (
    enc_emit |=> !enc_emit [*8]) else $error("encoder output too fast");
  chk_fault_on_alarm: assert property (
    alarm_r |=> !fault_out_n) else $error("fault output on during alarm");
  chk_ready_needs_power: assert property (
    !pin_r[P_MPWR] |=> !ready_out) else $error("ready without main power");
  chk_speed_detect: assert property (
    (mode_r != MODE_POS && motor_speed > SPD_W'(rot_spd_r)) |=> positioning_done)
    else $error("speed detect missed");

endmodule
`default_nettype wire

// ==== servo_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module servo_host_model import servo_io_pkg::*; (
  input  wire logic clk,
  output logic      pin_a,
  output logic      pin_b,
  output logic      servo_on,
  output logic      alarm_clear,
  output logic      dev_clear
);
  logic [1:0] ph = 2'h0;
  initial {pin_a, pin_b, servo_on, alarm_clear, dev_clear} = 5'h00;
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // 8-cycle levels leave margin over the drive's sync and agree filter
  task automatic send(input logic [1:0] fmt, input logic fwd, input int n);
    logic use_b;
    use_b = (fmt == FMT_CWCCW) && fwd;
    if (fmt[0]) begin
      pin_a <= 1'b0;
      pin_b <= (fmt == FMT_PDIR) && fwd;
      hold(8);
    end else if (!pin_a && !pin_b) ph = 2'h0;
    for (int i = 0; i < n; i++) begin
      if (!fmt[0]) begin
        ph = fwd ? ph + 2'h1 : ph - 2'h1;
        {pin_a, pin_b} <= {ph[1] ^ ph[0], ph[1]};
        hold(8);
      end else begin
        if (use_b) pin_b <= 1'b1;
        else pin_a <= 1'b1;
        hold(8);
        {pin_a, pin_b} <= {1'b0, pin_b & ~use_b};
        hold(8);
      end
    end
    pin_b <= pin_b & ~fmt[0];
    hold(8);
  endtask
  task automatic set_run(input logic v);
    servo_on <= v;
    hold(20);
  endtask
  task automatic clear_dev(input int ms_cyc);
    dev_clear <= 1'b1;
    hold(2 * ms_cyc + 8);
    dev_clear <= 1'b0;
    hold(8);
  endtask
  // run request goes first so the motor cannot restart on the clear
  task automatic clear_alarm(input int n);
    servo_on <= 1'b0;
    hold(8);
    alarm_clear <= 1'b1;
    hold(n);
    alarm_clear <= 1'b0;
    hold(8);
  endtask
endmodule
`default_nettype wire

// ==== servo_command_io_logic_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module servo_command_io_logic_bench import servo_io_pkg::*;;
  logic              ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [4:0]        reg_addr = 5'h00;
  logic [31:0]       reg_wdata = 32'h0, reg_rdata, seed = 32'h8e69;
  logic              forward_inhibit = 0, reverse_inhibit = 0, pulse_inhibit = 0, mode_switch_in = 0;
  logic              main_power_in = 0, fault_detect = 0, pa, pb, son, aclr, dclr, ea = 0, eb = 0, gsel = 0;
  logic              power_enable, ready_out, fault_out_n, brk_il, pos_done, fwd_blk, rev_blk, enc_a, enc_b;
  logic [1:0]        eab_d = 2'h0;
  logic [15:0]       mspd = 16'h0000;
  logic signed [15:0] spd_ref, trq_ref;
  logic [1:0]        stop_mode, active_mode;
  logic signed [15:0] torque_cmd_analog = 16'h0000;
  int                tests_run = 0, miscompares = 0, cyc = 0, enc_edges = 0;
  logic [4:0]        ra [5] = '{REG_CFG, REG_NUM, REG_DEN, REG_SPD_SCALE, 5'h1f};
  logic [15:0]       rv [5] = '{CFG_RST, RATIO_RST, RATIO_RST, SCALE_RST, ZERO16};
  logic [1:0]        fo [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
  servo_command_io_logic #(.ALM_CLR_CYCLES(20), .MS_CYCLES(4)) servo_command_io_logic_i (
    .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reverse_pulse_in(pa), .forward_pulse_in(pb), .enc_a_in(ea), .enc_b_in(eb),
    .forward_inhibit, .reverse_inhibit, .servo_on_in(son), .deviation_clear(dclr),
    .alarm_clear_in(aclr), .mode_switch_in, .pulse_inhibit, .gain_select_in(gsel),
    .main_power_in, .fault_detect, .motor_speed(mspd), .torque_cmd_analog,
    .power_enable, .brake_interlock(brk_il), .ready_out, .fault_out_n, .positioning_done(pos_done),
    .enc_a_out(enc_a), .enc_b_out(enc_b), .fwd_block(fwd_blk), .rev_block(rev_blk), .stop_mode, .active_mode,
    .speed_ref(spd_ref), .torque_ref(trq_ref));
  servo_host_model host_i (.clk(ref_clk), .pin_a(pa), .pin_b(pb), .servo_on(son),
    .alarm_clear(aclr), .dev_clear(dclr));
  initial forever #10 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] step_exp(input logic fwd, input logic inv, input logic blk, input int n);
    if (blk) return 32'h0;
    return (fwd ^ inv) ? n : -n;
  endfunction
  function automatic logic [1:0] mode_exp(input int m, input logic sw);
    case (m)
      1: return 2'h1;
      2: return 2'h2;
      3: return sw ? 2'h1 : 2'h0;
      4: return sw ? 2'h2 : 2'h0;
      5: return sw ? 2'h2 : 2'h1;
      default: return 2'h0;
    endcase
  endfunction
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // deviation delta over one burst, so earlier residue never matters
  task automatic burst(input logic [15:0] c, input logic fwd, input int n, input logic blk);
    logic [31:0] a, b;
    wr(REG_CFG, {16'h0, c});
    rd(REG_DEV, a);
    host_i.send(c[2:1], fwd, n);
    rd(REG_DEV, b);
    chk(b - a, step_exp(fwd, c[0], blk, n));
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    eab_d <= {enc_a, enc_b};
    if ({enc_a, enc_b} != eab_d) enc_edges <= enc_edges + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] v, w;
    logic [15:0] c;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    #1 chk({fault_out_n, ready_out, power_enable}, 0);
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk(v, {16'h0, rv[i]});
    end
    main_power_in <= 1'b1;
    pulse_inhibit <= 1'b1;
    wr(REG_CFG, 32'h4000);
    host_i.set_run(1'b1);
    chk({ready_out, fault_out_n, power_enable, brk_il}, 4'hf);
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      burst({2'h1, 11'h0, fo[k[1:0]], k[2]}, v[0], v[7:4] + 1, 1'b0);
    end
    $display("formats and direction done");
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      forward_inhibit <= v[0];
      reverse_inhibit <= v[1];
      pulse_inhibit <= v[2];
      c = 16'h4006 | {6'h0, v[6], 3'h0, v[5:4], v[3], 2'h0, v[7]};
      burst(c, v[8], 5, (!v[3] && (v[8] ^ v[7] ? v[0] : v[1])) || (!v[2] && !v[6]));
      chk({stop_mode, fwd_blk, rev_blk}, v[3] ? 4'h0 : {v[5:4], v[0], v[1]});
    end
    {forward_inhibit, reverse_inhibit, pulse_inhibit} <= 3'h1;
    $display("inhibits done");
    burst(16'h4006, 1'b1, 3, 1'b0);
    host_i.clear_dev(4);
    rd(REG_DEV, v);
    chk(v, 0);
    for (int k = 0; k < 12; k++) begin
      mode_switch_in <= k[0];
      torque_cmd_analog <= 16'(rnd());
      wr(REG_CFG, 32'h4000 | ((k >> 1) << 6));
      repeat (10) @(posedge ref_clk);
      w = mode_exp(k >> 1, k[0]);
      chk(active_mode, w);
      chk({spd_ref, trq_ref}, {w == 1 ? torque_cmd_analog : 16'h0, w == 2 ? torque_cmd_analog : 16'h0});
    end
    $display("modes done");
    gsel <= 1'b1;
    mspd <= 16'h0005;
    wr(REG_PRESET0 + 5'h5, 32'h1234);
    wr(REG_INP_RANGE, 32'h8);
    wr(REG_CFG, 32'h6040);
    repeat (10) @(posedge ref_clk);
    chk({spd_ref, 15'h0, pos_done}, 32'h12340001);
    mspd <= 16'h0000;
    burst(16'h4006, 1'b0, 2, 1'b0);
    chk(pos_done, 1);
    rd(REG_DEV, w);
    for (int i = 1; i <= 4; i++) begin
      repeat (8) @(posedge ref_clk);
      {ea, eb} <= {i[1] ^ i[0], i[1]};
    end
    repeat (60) @(posedge ref_clk);
    rd(REG_DEV, v);
    chk(v - w, 32'hfffffffc);
    chk(enc_edges, 4);
    fault_detect <= 1'b1;
    @(posedge ref_clk);
    fault_detect <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({fault_out_n, ready_out, power_enable, brk_il}, 0);
    host_i.clear_alarm(8);
    chk(fault_out_n, 0);
    host_i.clear_alarm(40);
    chk(fault_out_n, 1);
    rd(REG_DEV, v);
    chk(v, 0);
    host_i.set_run(1'b1);
    chk(power_enable, 1);
    $display("alarm clear done");
    end_sim();
  end
endmodule
`default_nettype wire
